/* File: logic/pin_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Pins and synchronised copy
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_s;

  sync_s s_reg;
  sync_s s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.meta = async_in;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.sync;

endmodule : pin_sync

/* File: logic/temp_conversion_standby_ctrl.sv */
// Conversion sequencer, standby control and AHB-Lite register file of a diode sensor
//
// Notes on behaviour
// - Address pins captured once after power-up
// - Standby pin low sleeps, high runs
// - Readings and thresholds kept during standby
// - Autoconvert starts sixteen conversions per second
// - Each conversion integrates over thirty ms
// - Result loaded, then compared with thresholds
// - Start by command or timer; result after end
// - Busy flag set throughout a conversion
// - Temperature reads give last completed result
// - Standby by pin low or run/stop set
// - Register access stays alive in standby
// - Pin standby ignores the one-shot command
// - Software standby still runs one-shot once
// - Pin standby beats every software request
// - Standby mid-conversion aborts (run/stop spares a one-shot), keeps old reading
// - Conversion period sixty-two ms, busy held
// - Alert output is open drain, low active
// - Serial data pin only pulled low
// - Alert when reading reaches a threshold
// - Thresholds reset to 7f and c9
// - Readings are 8-bit two's complement degrees
`timescale 1ns/10ps
module temp_conversion_standby_ctrl
  import tsense_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = PERIOD_CYC_DEF,
  parameter int unsigned CONV_CYC   = CONV_CYC_DEF,
  parameter int unsigned INTEG_CYC  = INTEG_CYC_DEF
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Device pins
  input  wire logic        hw_sleep_n,
  input  wire logic        addr_select_lo,
  input  wire logic        addr_select_hi,
  input  wire logic        smb_clk_in,
  input  wire logic        smb_data_in,
  output logic             smb_data_out,
  output logic             smb_data_oe,
  output logic             alert_out,
  output logic             alert_oe,
  output logic      [1:0]  smb_addr,
  // Analog front end
  input  wire logic [7:0]  adc_result,
  output logic             adc_en,
  output logic             adc_integrate
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [4:0] pins_s;
  logic       sleep_pin_s;
  logic       sel_lo_s;
  logic       sel_hi_s;
  logic       scl_s;
  logic       sda_s;

  // Straps, standby pin and serial lines all arrive unclocked
  pin_sync #(
    .W (5)
  ) pin_sync_i (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({hw_sleep_n, addr_select_lo, addr_select_hi, smb_clk_in, smb_data_in}),
    .sync_out (pins_s)
  );

  assign sleep_pin_s = pins_s[4];
  assign sel_lo_s    = pins_s[3];
  assign sel_hi_s    = pins_s[2];
  assign scl_s       = pins_s[1];
  assign sda_s       = pins_s[0];

  ////////////////////////////////////////////////////////////////////////////
  // State

  // Readings and thresholds sit here; standby stops the rate timer and timed conversions (run/stop still runs a one-shot) but keeps them
  typedef struct packed {
    conv_state_e      st;
    logic             run_stop;
    logic [7:0]       thigh;
    logic [7:0]       tlow;
    logic [7:0]       temp;
    logic             hi_alarm;
    logic             lo_alarm;
    logic             oneshot_pend;
    logic             conv_oneshot;
    logic [CNT_W-1:0] rate_cnt;
    logic [CNT_W-1:0] conv_cnt;
    logic [1:0]       addr;
    logic [1:0]       addr_cnt;
    logic             addr_done;
    logic             dp_write;
    logic [7:0]       dp_addr;
    logic [31:0]      hrdata;
    logic             sda_prev;
    logic             bus_active;
  } ctrl_s;

  ctrl_s s_reg;
  ctrl_s s_next;

  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] CONV_LAST   = CNT_W'(CONV_CYC - 1);
  localparam logic [CNT_W-1:0] INTEG_LEN   = CNT_W'(INTEG_CYC);

  // Signed threshold test, shared by both alarms
  function automatic logic reaches(input logic [7:0] a, input logic [7:0] b);
    return $signed(a) >= $signed(b);
  endfunction : reaches

  logic sleep_hw;
  logic sleep_any;
  logic timer_fire;
  logic abort;
  logic addr_ph;

  always_comb begin
    s_next     = s_reg;
    sleep_hw   = !sleep_pin_s;
    sleep_any  = sleep_hw || s_reg.run_stop;
    // A wrap while converting is lost; the next wrap starts one
    timer_fire = !sleep_any && (s_reg.rate_cnt == PERIOD_LAST);
    // A one-shot conversion is not cut short by the stop bit that allowed it
    abort      = sleep_hw || (s_reg.run_stop && !s_reg.conv_oneshot);
    // Only whole-word transfers count; other sizes read zero
    addr_ph    = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);

    // Capture address straps once the synchronisers have settled
    if (!s_reg.addr_done) begin
      if (s_reg.addr_cnt == 2'(ADDR_WAIT)) begin
        s_next.addr      = {sel_hi_s, sel_lo_s};
        s_next.addr_done = 1'b1;
      end else begin
        s_next.addr_cnt = s_reg.addr_cnt + 2'h1;
      end
    end

    // Bus activity between start and stop conditions
    s_next.sda_prev = sda_s;
    if (scl_s && s_reg.sda_prev && !sda_s) begin
      s_next.bus_active = 1'b1;
    end else if (scl_s && !s_reg.sda_prev && sda_s) begin
      s_next.bus_active = 1'b0;
    end

    // Rate timer held at zero in either standby
    if (sleep_any || (s_reg.rate_cnt == PERIOD_LAST)) begin
      s_next.rate_cnt = '0;
    end else begin
      s_next.rate_cnt = s_reg.rate_cnt + CNT_W'(1);
    end

    case (s_reg.st)
      ST_IDLE: begin
        if (!sleep_hw && (s_reg.oneshot_pend || timer_fire)) begin
          s_next.st           = ST_CONV;
          s_next.conv_cnt     = '0;
          s_next.conv_oneshot = s_reg.oneshot_pend;
          s_next.oneshot_pend = 1'b0;
        end
      end
      ST_CONV: begin
        if (abort) begin
          s_next.st = ST_IDLE;
        end else if (s_reg.conv_cnt == CONV_LAST) begin
          s_next.temp = adc_result;
          s_next.st   = ST_CMP;
        end else begin
          s_next.conv_cnt = s_reg.conv_cnt + CNT_W'(1);
        end
      end
      // A cycle after the load, so the compare sees the new reading
      ST_CMP: begin
        s_next.hi_alarm = reaches(s_reg.temp, s_reg.thigh);
        s_next.lo_alarm = reaches(s_reg.tlow, s_reg.temp);
        s_next.st       = ST_IDLE;
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase

    // Register writes, taken in the data phase; work in any standby except a one-shot write under pin standby
    if (s_reg.dp_write) begin
      if (s_reg.dp_addr == OFS_CONFIG) begin
        s_next.run_stop = hwdata[CFG_RUN_STOP_BIT];
      end else if (s_reg.dp_addr == OFS_THIGH) begin
        s_next.thigh = hwdata[7:0];
      end else if (s_reg.dp_addr == OFS_TLOW) begin
        s_next.tlow = hwdata[7:0];
      end else if (s_reg.dp_addr == OFS_ONESHOT) begin
        s_next.oneshot_pend = 1'b1;
      end
    end
    if (sleep_hw) begin
      s_next.oneshot_pend = 1'b0;
    end

    s_next.dp_write = addr_ph && hwrite;
    s_next.dp_addr  = haddr[7:0];

    // Read data built from next state so a write just ahead is seen
    s_next.hrdata = 32'h0;
    if (addr_ph && !hwrite) begin
      if (haddr[7:0] == OFS_TEMP) begin
        s_next.hrdata[7:0] = s_next.temp;
      end else if (haddr[7:0] == OFS_STATUS) begin
        s_next.hrdata[STS_BUSY_BIT]     = (s_next.st == ST_CONV);
        s_next.hrdata[STS_HI_BIT]       = s_next.hi_alarm;
        s_next.hrdata[STS_LO_BIT]       = s_next.lo_alarm;
        s_next.hrdata[STS_HW_SLEEP_BIT] = sleep_hw;
        s_next.hrdata[STS_SW_SLEEP_BIT] = s_next.run_stop;
        s_next.hrdata[STS_BUS_ACT_BIT]  = s_next.bus_active;
      end else if (haddr[7:0] == OFS_ADDR) begin
        s_next.hrdata[1:0] = s_next.addr;
      end else if (haddr[7:0] == OFS_CONFIG) begin
        s_next.hrdata[CFG_RUN_STOP_BIT] = s_next.run_stop;
      end else if (haddr[7:0] == OFS_THIGH) begin
        s_next.hrdata[7:0] = s_next.thigh;
      end else if (haddr[7:0] == OFS_TLOW) begin
        s_next.hrdata[7:0] = s_next.tlow;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg              <= '0;
      s_reg.st           <= ST_IDLE;
      s_reg.thigh        <= THIGH_RST;
      s_reg.tlow         <= TLOW_RST;
      s_reg.temp         <= TEMP_RST;
      s_reg.sda_prev     <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero wait states: every register answers in its data phase
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = s_reg.hrdata;
  assign smb_addr      = s_reg.addr;
  // Framing lives elsewhere; this end never drives the data line high
  assign smb_data_out  = 1'b0;
  assign smb_data_oe   = 1'b0;
  assign alert_out     = 1'b0;
  assign alert_oe      = s_reg.hi_alarm || s_reg.lo_alarm;
  // Busy and converter enable are one level
  assign adc_en        = (s_reg.st == ST_CONV);
  assign adc_integrate = (s_reg.st == ST_CONV) && (s_reg.conv_cnt < INTEG_LEN);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Everything here is on the bus clock and sleeps in reset
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  addr_frozen_a: assert property (s_reg.addr_done |=> s_reg.addr_done && $stable(s_reg.addr))
    else $error("address straps changed after capture");

  pin_blocks_a: assert property (sleep_hw && s_reg.st == ST_IDLE |=> s_reg.st == ST_IDLE)
    else $error("conversion started under pin standby");

  oneshot_drop_a: assert property (sleep_hw |=> !s_reg.oneshot_pend)
    else $error("one-shot kept under pin standby");

  temp_hold_a: assert property (
    !(s_reg.st == ST_CONV && !abort && s_reg.conv_cnt == CONV_LAST) |=> $stable(s_reg.temp))
    else $error("reading changed outside conversion end");

  abort_conv_a: assert property (
    s_reg.st == ST_CONV && abort |=> s_reg.st == ST_IDLE && $stable(s_reg.temp))
    else $error("aborted conversion not dropped");

  busy_hold_a: assert property (
    s_reg.st == ST_CONV && !abort && s_reg.conv_cnt < CONV_LAST |=> adc_en)
    else $error("busy dropped early");

  // Thresholds taken as they stood when the compare ran
  cmp_result_a: assert property (
    s_reg.st == ST_CMP |=>
      s_reg.hi_alarm == reaches($past(s_reg.temp), $past(s_reg.thigh)) &&
      s_reg.lo_alarm == reaches($past(s_reg.tlow), $past(s_reg.temp)))
    else $error("threshold compare wrong");

  timer_stop_a: assert property (sleep_any |=> s_reg.rate_cnt == '0)
    else $error("rate timer ran in standby");

  rate_fire_a: assert property (timer_fire && s_reg.st == ST_IDLE |=> s_reg.st == ST_CONV)
    else $error("timer did not start conversion");

  sw_oneshot_a: assert property (
    s_reg.run_stop && !sleep_hw && s_reg.oneshot_pend && s_reg.st == ST_IDLE
      |=> s_reg.st == ST_CONV)
    else $error("one-shot ignored in software standby");

  sda_low_only_a: assert property (!(smb_data_oe && smb_data_out) && !alert_out)
    else $error("open-drain pin driven high");

  thresh_keep_a: assert property (!s_reg.dp_write |=> $stable(s_reg.thigh) && $stable(s_reg.tlow))
    else $error("threshold changed without a write");

  integ_end_a: assert property (
    s_reg.st == ST_CONV && !abort && s_reg.conv_cnt == INTEG_LEN - 1'b1
      |-> adc_integrate ##1 !adc_integrate)
    else $error("integration window length wrong");

  temp_load_a: assert property (
    s_reg.st == ST_CONV && !abort && s_reg.conv_cnt == CONV_LAST
      |=> s_reg.st == ST_CMP && s_reg.temp == $past(adc_result))
    else $error("result not loaded at conversion end");

  // A stuck or skipped count would stretch the rate silently
  rate_step_a: assert property (
    !sleep_any && s_reg.rate_cnt != PERIOD_LAST
      |=> s_reg.rate_cnt == $past(s_reg.rate_cnt) + 1'b1)
    else $error("rate timer skipped a count");

  read_idle_a: assert property (
    !(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
    else $error("read data left standing");

  oneshot_set_a: assert property (
    s_reg.dp_write && s_reg.dp_addr == OFS_ONESHOT && !sleep_hw |=> s_reg.oneshot_pend)
    else $error("one-shot request lost");

endmodule : temp_conversion_standby_ctrl

/* File: logic/tsense_pkg.sv */
// Shared constants for the temperature conversion and standby controller
package tsense_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_TEMP    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_ADDR    = 8'h08;
  localparam logic [7:0] OFS_CONFIG  = 8'h0c;
  localparam logic [7:0] OFS_THIGH   = 8'h10;
  localparam logic [7:0] OFS_TLOW    = 8'h14;
  localparam logic [7:0] OFS_ONESHOT = 8'h18;

  // Field positions
  localparam int unsigned CFG_RUN_STOP_BIT = 0;
  localparam int unsigned STS_BUSY_BIT     = 0;
  localparam int unsigned STS_HI_BIT       = 1;
  localparam int unsigned STS_LO_BIT       = 2;
  localparam int unsigned STS_HW_SLEEP_BIT = 3;
  localparam int unsigned STS_SW_SLEEP_BIT = 4;
  localparam int unsigned STS_BUS_ACT_BIT  = 5;

  // Reset values
  localparam logic [7:0] THIGH_RST = 8'h7f;
  localparam logic [7:0] TLOW_RST  = 8'hc9;
  localparam logic [7:0] TEMP_RST  = 8'h00;

  // Timing
  localparam int unsigned CLK_HZ        = 20000000;
  localparam int unsigned RATE_HZ       = 16;
  localparam int unsigned CONV_TIME_US  = 62000;
  localparam int unsigned INTEG_TIME_US = 30000;
  localparam int unsigned PERIOD_CYC_DEF = CLK_HZ / RATE_HZ;
  localparam int unsigned CONV_CYC_DEF   = CONV_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned INTEG_CYC_DEF  = INTEG_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned CNT_W          = 21;
  localparam int unsigned ADDR_WAIT      = 3;

  // AHB encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_CMP  = 3'b100
  } conv_state_e;

endpackage : tsense_pkg

/* File: verif/smb_host_model.sv */
// Serial host model: framed byte writes on an open-drain data line
`timescale 1ns/10ps
module smb_host_model (
  // Wire levels seen by the device
  output logic      scl,
  output logic      sda,
  // Device pull-down enable
  input  wire logic sda_oe
);
  logic host_sda;

  // Pull-up wire: either party can only pull it low
  assign sda = host_sda & ~sda_oe;

  initial begin
    scl      = 1'b1;
    host_sda = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start, eight data bits plus a released bit at 400 ns, then stop
  task automatic frame(input logic [7:0] b);
    host_sda = 1'b0;
    #200;
    for (int i = 7; i >= -1; i--) begin
      scl = 1'b0;
      #100;
      host_sda = (i >= 0) ? b[i] : 1'b1;
      #100;
      scl = 1'b1;
      #200;
    end
    scl = 1'b0;
    #100;
    host_sda = 1'b0;
    #100;
    scl = 1'b1;
    #100;
    host_sda = 1'b1;
    // Bus free time, so the stop is seen before the next request
    #400;
  endtask : frame
endmodule : smb_host_model

/* File: verif/tb_temp_conversion_standby_ctrl.sv */
// Register-level testbench of the conversion and standby controller
`timescale 1ns/10ps
module tb_temp_conversion_standby_ctrl;
  import tsense_pkg::*;
  // Short counts keep the run small
  localparam int unsigned PER   = 200;
  localparam int unsigned CNV   = 100;
  localparam int unsigned INTEG = 40;

  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans, smb_addr;
  logic [2:0]  hsize;
  logic        hw_sleep_n, addr_select_lo, addr_select_hi, scl, sda;
  logic        smb_data_out, smb_data_oe, alert_out, alert_oe, adc_en, adc_integrate;
  logic [7:0]  adc_result, adc_val;
  int          fails, samples_checked, n, n2, n3;

  assign hready = hreadyout;

  temp_conversion_standby_ctrl #(.PERIOD_CYC(PER), .CONV_CYC(CNV), .INTEG_CYC(INTEG))
    temp_conversion_standby_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .hw_sleep_n(hw_sleep_n), .addr_select_lo(addr_select_lo),
    .addr_select_hi(addr_select_hi), .smb_clk_in(scl), .smb_data_in(sda),
    .smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe), .alert_out(alert_out),
    .alert_oe(alert_oe), .smb_addr(smb_addr), .adc_result(adc_result), .adc_en(adc_en),
    .adc_integrate(adc_integrate));

  smb_host_model smb_host_model_i (.scl(scl), .sda(sda), .sda_oe(smb_data_oe));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Front end: result only meaningful while converting, inverse otherwise
  always @(posedge hclk) adc_result <= adc_en ? adc_val : ~adc_val;

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    // Address phase holds until hready is seen high at a rising edge
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    // Taken at the closing edge, before the slave's registers move on
    r = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(what, r, exp);
    check("bus response", {31'h0, hresp}, 32'h0);
  endtask : rd_chk

  // Counts cycles until the chosen output reaches level lv, at most lim
  task automatic wait_sig(input logic integ, input logic lv, input int lim, output int c);
    c = 0;
    do begin
      @(negedge hclk);
      c++;
    end while (((integ ? adc_integrate : adc_en) !== lv) && c < lim);
  endtask : wait_sig

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(20000 * 50);
    fails++;
    print_verdict();
  end

  initial begin
    {hresetn, htrans, hwrite, haddr, hwdata, hw_sleep_n, addr_select_hi} = '0;
    {hsel, addr_select_lo} = 2'b11;
    hsize   = HSIZE_WORD;
    adc_val = 8'h25;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    // Straps move after capture; address must not follow
    addr_select_lo <= 1'b0;
    addr_select_hi <= 1'b1;
    rd_chk("addr reg", OFS_ADDR, 32'h1);
    check("addr pins", {30'h0, smb_addr}, 32'h1);
    rd_chk("thigh reset", OFS_THIGH, 32'h7f);
    rd_chk("tlow reset", OFS_TLOW, 32'hc9);
    rd_chk("unmapped", 8'h40, 32'h0);
    // Partial-word reads are ignored, answer OKAY and read zero
    hsize <= 3'h0;
    rd_chk("byte read", OFS_THIGH, 32'h0);
    hsize <= HSIZE_WORD;
    // Pin standby: one-shot dropped, bus still served
    wr(OFS_ONESHOT, 32'h1);
    wr(OFS_THIGH, 32'h20);
    wait_sig(1'b0, 1'b1, 2 * PER, n);
    check("pin standby start", n, 2 * PER);
    fork
      smb_host_model_i.frame(8'h55);
      begin
        repeat (20) @(posedge hclk);
        xfer(1'b0, OFS_STATUS, 32'h0, v);
        check("bus active", v[STS_BUS_ACT_BIT], 1);
      end
    join
    rd_chk("thigh asleep", OFS_THIGH, 32'h20);
    rd_chk("status asleep", OFS_STATUS, 32'h8);
    // Software standby: timer blocked, one-shot runs once
    wr(OFS_CONFIG, 32'h1);
    hw_sleep_n <= 1'b1;
    repeat (2 * PER) @(posedge hclk);
    rd_chk("temp sw standby", OFS_TEMP, 32'h0);
    wr(OFS_ONESHOT, 32'h1);
    wait_sig(1'b0, 1'b1, 20, n);
    xfer(1'b0, OFS_STATUS, 32'h0, v);
    check("busy", v[STS_BUSY_BIT], 1);
    rd_chk("temp busy", OFS_TEMP, 32'h0);
    wait_sig(1'b0, 1'b0, CNV + 10, n);
    rd_chk("one-shot temp", OFS_TEMP, 32'h25);
    xfer(1'b0, OFS_STATUS, 32'h0, v);
    check("alarms hi", v[2:0], 3'b010);
    check("alert pull", alert_oe, 1);
    check("alert level", alert_out, 0);
    adc_val <= 8'h10;
    repeat (2 * PER) @(posedge hclk);
    rd_chk("one conversion only", OFS_TEMP, 32'h25);
    // Pin standby in mid conversion truncates it
    wr(OFS_ONESHOT, 32'h1);
    wait_sig(1'b0, 1'b1, 20, n);
    repeat (20) @(posedge hclk);
    hw_sleep_n <= 1'b0;
    wait_sig(1'b0, 1'b0, 10, n);
    check("pin abort", n < 6, 1);
    rd_chk("temp kept", OFS_TEMP, 32'h25);
    // Autoconvert timing and signed compare
    hw_sleep_n <= 1'b1;
    adc_val    <= 8'he0;
    wr(OFS_TLOW, 32'he0);
    wr(OFS_CONFIG, 32'h0);
    wait_sig(1'b0, 1'b1, PER + 20, n);
    wait_sig(1'b1, 1'b0, CNV, n);
    check("integrate", n, INTEG);
    wait_sig(1'b0, 1'b0, CNV, n2);
    check("busy span", (n + n2 >= CNV) && (n + n2 <= CNV + 2), 1);
    wait_sig(1'b0, 1'b1, PER, n3);
    check("rate", n + n2 + n3, PER);
    rd_chk("auto temp", OFS_TEMP, 32'he0);
    xfer(1'b0, OFS_STATUS, 32'h0, v);
    check("alarms lo", v[2:1], 2'b10);
    // Run/stop set in mid conversion truncates it
    wait_sig(1'b0, 1'b1, PER, n);
    adc_val <= 8'h05;
    wr(OFS_CONFIG, 32'h1);
    wait_sig(1'b0, 1'b0, 10, n);
    check("sw abort", n < 10, 1);
    rd_chk("temp kept sw", OFS_TEMP, 32'he0);
    rd_chk("tlow kept", OFS_TLOW, 32'he0);
    check("data pin", {smb_data_oe, smb_data_out}, 2'b00);
    print_verdict();
  end
endmodule : tb_temp_conversion_standby_ctrl
